/* hw/can_txreq_pkg.sv */
/*
 * constants for the mailbox transmit request, cancel and acknowledge block.
 * assumes a 16-bit register port and a protocol engine that reports per-mailbox events.
 */
package can_txreq_pkg;
    localparam int unsigned data_width = 16;
    localparam int unsigned addr_width = 4;
    localparam logic [3:0] wait_request_offset = 4'h0;
    localparam logic [3:0] wait_cancel_offset = 4'h1;
    localparam logic [3:0] done_flags_offset = 4'h2;
    localparam logic [3:0] abort_flags_offset = 4'h3;
    localparam logic [3:0] irq_status_offset = 4'h4;
    localparam logic [3:0] irq_mask_offset = 4'h5;
    localparam int unsigned reserved_bit = 8;
    localparam logic [15:0] mailbox_mask = 16'hfeff;
    localparam logic [15:0] reserved_one = 16'h0100;
    localparam logic [15:0] reg_reset = 16'h0000;
    localparam logic [1:0] irq_reset = 2'h0;
    localparam int unsigned irq_done_bit = 0;
    localparam int unsigned irq_abort_bit = 1;
endpackage : can_txreq_pkg

/* hw/can_mailbox_tx_request_control.sv */
/*
 * per-mailbox transmit wait, cancel and completion flags with register port and interrupt.
 * assumes the protocol engine pulses done/abort per mailbox, in register bit layout.
 */
// Operation
// R1: one wait, cancel, ack bit per mailbox 1-15; bit 8 reserved, odd bit map.
// R2: writing wait bit 1 puts mailbox message into arbitration wait.
// R3: wait bit clears when that mailbox's transmission completes.
// R4: wait bit clears when that mailbox's cancellation completes.
// R5: writing cancel bit 1 cancels the waiting message in that mailbox.
// R6: cancel bit clears after normal cancellation, once wait bit is cleared.
// R7: ack flag set on error-free transmit; write 1 clears, 0 ignored.
// R8: wait register bit 8 reads 1; software writes 1.
// R9: cancel and ack register bit 8 read 0; software writes 0.
// R10: all mailbox bits of the three registers reset to 0.
// R11: abort-ack flag set on error-free cancel; write 1 clears.
// R12: transmit and cancel resolving together report exactly one outcome.
`timescale 1ns/1ps
module can_mailbox_tx_request_control (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // protocol engine side
    output logic [15:0] tx_pending,
    output logic [15:0] cancel_pending,
    input wire logic [15:0] tx_complete,
    input wire logic [15:0] cancel_complete,
    // interrupt
    output logic irq
);
    logic [15:0] wait_reg, wait_next;
    logic [15:0] cancel_reg, cancel_next;
    logic [15:0] done_reg, done_next;
    logic [15:0] abort_reg, abort_next;
    logic [1:0] irq_stat_reg, irq_stat_next;
    logic [1:0] irq_mask_reg, irq_mask_next;
    logic [15:0] rdata_reg, rdata_next;
    logic irq_reg;

    wire logic wr_wait = reg_write && reg_addr == can_txreq_pkg::wait_request_offset;
    wire logic wr_cancel = reg_write && reg_addr == can_txreq_pkg::wait_cancel_offset;
    wire logic wr_done = reg_write && reg_addr == can_txreq_pkg::done_flags_offset;
    wire logic wr_abort = reg_write && reg_addr == can_txreq_pkg::abort_flags_offset;
    wire logic wr_istat = reg_write && reg_addr == can_txreq_pkg::irq_status_offset;
    wire logic wr_imask = reg_write && reg_addr == can_txreq_pkg::irq_mask_offset;
    wire logic [15:0] wmask = reg_wdata & can_txreq_pkg::mailbox_mask; // R1
    // events only count for mailboxes actually waiting; transmit wins a tie
    wire logic [15:0] tx_ev = tx_complete & wait_reg & can_txreq_pkg::mailbox_mask;
    wire logic [15:0] ab_ev = cancel_complete & wait_reg & cancel_reg
        & can_txreq_pkg::mailbox_mask & ~tx_ev; // R12
    wire logic [15:0] set_wait = wr_wait ? wmask : 16'h0000;
    wire logic [15:0] set_cancel = wr_cancel ? (wmask & wait_reg) : 16'h0000;
    wire logic [15:0] clr_done = wr_done ? wmask : 16'h0000;
    wire logic [15:0] clr_abort = wr_abort ? wmask : 16'h0000;

    // software cannot withdraw a wait by writing 0; only completion clears it
    assign wait_next = (wait_reg | set_wait) & ~(tx_ev | ab_ev); // R2 R3 R4
    // a cancel also ends when the message wins arbitration first
    assign cancel_next = (cancel_reg | set_cancel) & ~(tx_ev | ab_ev); // R5 R6
    assign done_next = (done_reg & ~clr_done) | tx_ev; // R7
    assign abort_next = (abort_reg & ~clr_abort) | ab_ev; // R11
    assign irq_stat_next = ((irq_stat_reg & ~(wr_istat ? reg_wdata[1:0] : 2'h0))
        | {|ab_ev, |tx_ev});
    assign irq_mask_next = wr_imask ? reg_wdata[1:0] : irq_mask_reg;

    wire logic [15:0] rd_sel =
        reg_addr == can_txreq_pkg::wait_request_offset ? (wait_reg | can_txreq_pkg::reserved_one) :
        reg_addr == can_txreq_pkg::wait_cancel_offset ? cancel_reg :
        reg_addr == can_txreq_pkg::done_flags_offset ? done_reg :
        reg_addr == can_txreq_pkg::abort_flags_offset ? abort_reg :
        reg_addr == can_txreq_pkg::irq_status_offset ? {14'h0000, irq_stat_reg} :
        reg_addr == can_txreq_pkg::irq_mask_offset ? {14'h0000, irq_mask_reg} :
        16'h0000; // R8 R9
    assign rdata_next = reg_read ? rd_sel : 16'h0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_reg <= can_txreq_pkg::reg_reset; // R10
            cancel_reg <= can_txreq_pkg::reg_reset;
            done_reg <= can_txreq_pkg::reg_reset;
            abort_reg <= can_txreq_pkg::reg_reset;
            irq_stat_reg <= can_txreq_pkg::irq_reset;
            irq_mask_reg <= can_txreq_pkg::irq_reset;
            rdata_reg <= can_txreq_pkg::reg_reset;
            irq_reg <= 1'b0;
        end else begin
            wait_reg <= wait_next;
            cancel_reg <= cancel_next;
            done_reg <= done_next;
            abort_reg <= abort_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= |(irq_stat_next & irq_mask_next);
        end
    end

    assign reg_rdata = rdata_reg;
    assign tx_pending = wait_reg;
    assign cancel_pending = cancel_reg;
    assign irq = irq_reg;

    // read strobes per register, only the checks below use them
    wire logic rd_wait = reg_read && reg_addr == can_txreq_pkg::wait_request_offset;
    wire logic rd_cancel = reg_read && reg_addr == can_txreq_pkg::wait_cancel_offset;
    wire logic rd_done = reg_read && reg_addr == can_txreq_pkg::done_flags_offset;
    wire logic rd_abort = reg_read && reg_addr == can_txreq_pkg::abort_flags_offset;
    wire logic rd_spare = reg_read && reg_addr > can_txreq_pkg::irq_mask_offset;

    sequence s_tx_resolves(int unsigned m);
        wait_reg[m] && tx_complete[m];
    endsequence

    sequence s_ab_resolves(int unsigned m);
        wait_reg[m] && cancel_reg[m] && cancel_complete[m] && !tx_complete[m];
    endsequence

    sequence s_sw_waits(int unsigned m);
        wr_wait && reg_wdata[m] && !tx_ev[m] && !ab_ev[m];
    endsequence

    sequence s_sw_cancels(int unsigned m);
        wr_cancel && reg_wdata[m] && wait_reg[m] && !tx_ev[m] && !ab_ev[m];
    endsequence

    a_wait_set: assert property (@(posedge clk) disable iff (!resetn) // R2
        s_sw_waits(3) |=> wait_reg[3])
        else $error("wait bit not set by write");

    a_wait_clr_tx: assert property (@(posedge clk) disable iff (!resetn) // R3
        s_tx_resolves(3) |=> !wait_reg[3] && done_reg[3])
        else $error("wait bit not cleared on transmit");

    a_wait_clr_ab: assert property (@(posedge clk) disable iff (!resetn) // R4
        s_ab_resolves(15) |=> !wait_reg[15] && !cancel_reg[15])
        else $error("wait or cancel not cleared on abort");

    a_cancel_hold: assert property (@(posedge clk) disable iff (!resetn) // R6
        cancel_reg[15] && !tx_ev[15] && !ab_ev[15] |=> cancel_reg[15])
        else $error("cancel bit dropped early");

    a_done_w1c: assert property (@(posedge clk) disable iff (!resetn) // R7
        done_reg[3] && !(wr_done && reg_wdata[3]) |=> done_reg[3])
        else $error("ack flag lost without write one");

    a_abort_set: assert property (@(posedge clk) disable iff (!resetn) // R11
        ab_ev[15] |=> abort_reg[15])
        else $error("abort flag not set");

    a_reserved_read: assert property (@(posedge clk) disable iff (!resetn) // R8
        reg_read && reg_addr == can_txreq_pkg::wait_request_offset |=> reg_rdata[8])
        else $error("reserved wait bit not one");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn) // R9
        !cancel_reg[8] && !done_reg[8] && !abort_reg[8] && !wait_reg[8])
        else $error("reserved bit stored");

    a_one_outcome: assert property (@(posedge clk) disable iff (!resetn) // R12
        $rose(done_reg[0]) |-> !$rose(abort_reg[0]))
        else $error("both outcomes reported");

    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        ##1 irq == |(irq_stat_reg & irq_mask_reg))
        else $error("irq mismatch");

    // two low edges: the first one may still see the flops before reset took hold
    a_reset_clear: assert property (@(posedge clk) // R10
        !resetn ##1 !resetn |-> (wait_reg | cancel_reg | done_reg | abort_reg) == 16'h0000)
        else $error("register not cleared in reset");

    a_cancel_rd_zero: assert property (@(posedge clk) disable iff (!resetn) // R9
        rd_cancel |=> !reg_rdata[8])
        else $error("reserved cancel bit not zero");

    a_done_rd_zero: assert property (@(posedge clk) disable iff (!resetn) // R9
        rd_done |=> !reg_rdata[8])
        else $error("reserved ack bit not zero");

    a_abort_rd_zero: assert property (@(posedge clk) disable iff (!resetn)
        rd_abort |=> !reg_rdata[8])
        else $error("reserved abort bit not zero");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");

    a_irq_tx_stat: assert property (@(posedge clk) disable iff (!resetn)
        |tx_ev |=> irq_stat_reg[can_txreq_pkg::irq_done_bit])
        else $error("transmit status not set");

    a_irq_ab_stat: assert property (@(posedge clk) disable iff (!resetn)
        |ab_ev |=> irq_stat_reg[can_txreq_pkg::irq_abort_bit])
        else $error("abort status not set");

    // every mailbox bit gets the same checks; bit 8 holds no mailbox
    for (genvar m = 0; m < 16; m++) begin : g_mbox
        if (m != can_txreq_pkg::reserved_bit) begin : g_used
            a_wait_write: assert property (@(posedge clk) disable iff (!resetn) // R2
                s_sw_waits(m) |=> wait_reg[m])
                else $error("wait write lost");

            a_wait_sticky: assert property (@(posedge clk) disable iff (!resetn) // R2
                wait_reg[m] && !tx_ev[m] && !ab_ev[m] |=> wait_reg[m])
                else $error("wait bit dropped without event");

            a_wait_quiet: assert property (@(posedge clk) disable iff (!resetn) // R2
                !wait_reg[m] && !(wr_wait && reg_wdata[m]) |=> !wait_reg[m])
                else $error("wait bit set without write");

            a_wait_tx_end: assert property (@(posedge clk) disable iff (!resetn) // R3
                s_tx_resolves(m) |=> !wait_reg[m])
                else $error("wait kept after transmit");

            a_wait_ab_end: assert property (@(posedge clk) disable iff (!resetn) // R4
                s_ab_resolves(m) |=> !wait_reg[m])
                else $error("wait kept after cancel");

            a_cancel_write: assert property (@(posedge clk) disable iff (!resetn) // R5
                s_sw_cancels(m) |=> cancel_reg[m])
                else $error("cancel write lost");

            a_cancel_refused: assert property (@(posedge clk) disable iff (!resetn) // R5
                !wait_reg[m] && !cancel_reg[m] |=> !cancel_reg[m])
                else $error("cancel taken for idle mailbox");

            a_cancel_sticky: assert property (@(posedge clk) disable iff (!resetn) // R6
                cancel_reg[m] && !tx_ev[m] && !ab_ev[m] |=> cancel_reg[m])
                else $error("cancel dropped without event");

            a_cancel_end: assert property (@(posedge clk) disable iff (!resetn) // R6
                s_ab_resolves(m) |=> !cancel_reg[m])
                else $error("cancel kept after cancellation");

            a_cancel_in_wait: assert property (@(posedge clk) disable iff (!resetn) // R6
                cancel_reg[m] |-> wait_reg[m])
                else $error("cancel without wait");

            a_done_set: assert property (@(posedge clk) disable iff (!resetn) // R7
                s_tx_resolves(m) |=> done_reg[m])
                else $error("ack flag not set");

            a_done_clear: assert property (@(posedge clk) disable iff (!resetn) // R7
                done_reg[m] && wr_done && reg_wdata[m] && !tx_ev[m] |=> !done_reg[m])
                else $error("ack flag not cleared by one");

            a_done_hold: assert property (@(posedge clk) disable iff (!resetn) // R7
                done_reg[m] && !(wr_done && reg_wdata[m]) |=> done_reg[m])
                else $error("ack flag lost");

            a_done_quiet: assert property (@(posedge clk) disable iff (!resetn) // R7
                !done_reg[m] && !tx_ev[m] |=> !done_reg[m])
                else $error("ack flag set without transmit");

            a_abort_flag: assert property (@(posedge clk) disable iff (!resetn) // R11
                s_ab_resolves(m) |=> abort_reg[m])
                else $error("abort flag not set");

            a_abort_clear: assert property (@(posedge clk) disable iff (!resetn) // R11
                abort_reg[m] && wr_abort && reg_wdata[m] && !ab_ev[m] |=> !abort_reg[m])
                else $error("abort flag not cleared by one");

            a_abort_hold: assert property (@(posedge clk) disable iff (!resetn) // R11
                abort_reg[m] && !(wr_abort && reg_wdata[m]) |=> abort_reg[m])
                else $error("abort flag lost");

            a_abort_quiet: assert property (@(posedge clk) disable iff (!resetn) // R11
                !abort_reg[m] && !ab_ev[m] |=> !abort_reg[m])
                else $error("abort flag set without cancel");

            a_tie_tx_wins: assert property (@(posedge clk) disable iff (!resetn) // R12
                s_tx_resolves(m) && cancel_reg[m] && cancel_complete[m] && !abort_reg[m]
                |=> done_reg[m] && !abort_reg[m])
                else $error("tie gave wrong outcome");

            a_tie_cancel_end: assert property (@(posedge clk) disable iff (!resetn) // R12
                s_tx_resolves(m) && cancel_reg[m] |=> !cancel_reg[m])
                else $error("cancel kept after transmit");

            a_tx_ignored: assert property (@(posedge clk) disable iff (!resetn) // R7
                !wait_reg[m] && tx_complete[m] && !done_reg[m] |=> !done_reg[m])
                else $error("transmit taken for idle mailbox");

            a_ab_ignored: assert property (@(posedge clk) disable iff (!resetn) // R11
                !cancel_reg[m] && cancel_complete[m] && !abort_reg[m] |=> !abort_reg[m])
                else $error("cancel taken without request");

            a_rd_wait: assert property (@(posedge clk) disable iff (!resetn) // R2
                rd_wait |=> reg_rdata[m] == $past(wait_reg[m]))
                else $error("wait read back wrong");

            a_rd_cancel: assert property (@(posedge clk) disable iff (!resetn) // R5
                rd_cancel |=> reg_rdata[m] == $past(cancel_reg[m]))
                else $error("cancel read back wrong");

            a_rd_done: assert property (@(posedge clk) disable iff (!resetn) // R7
                rd_done |=> reg_rdata[m] == $past(done_reg[m]))
                else $error("ack read back wrong");

            a_rd_abort: assert property (@(posedge clk) disable iff (!resetn) // R11
                rd_abort |=> reg_rdata[m] == $past(abort_reg[m]))
                else $error("abort read back wrong");

            a_rd_spare: assert property (@(posedge clk) disable iff (!resetn)
                rd_spare |=> !reg_rdata[m])
                else $error("unmapped index read not zero");
        end
    end
endmodule : can_mailbox_tx_request_control

/* verif/can_engine_model.sv */
/* protocol engine stand-in: ends each pending transmit or cancel with a one-cycle pulse.
 * assumes the bench opens send_en/cancel_en per mailbox to pick prompt or slow answers. */
`timescale 1ns/1ps
module can_engine_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // block side and bench knobs
    input wire logic [15:0] tx_pending,
    input wire logic [15:0] cancel_pending,
    input wire logic [15:0] send_en,
    input wire logic [15:0] cancel_en,
    output logic [15:0] tx_complete,
    output logic [15:0] cancel_complete
);
    logic [15:0] busy;
    // pending drops one edge after the pulse, so gate on our own pulse to avoid a repeat
    assign busy = tx_complete | cancel_complete;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_complete <= 16'h0000;
            cancel_complete <= 16'h0000;
        end else begin
            tx_complete <= tx_pending & send_en & ~busy;
            cancel_complete <= tx_pending & cancel_pending & cancel_en & ~busy;
        end
    end
endmodule : can_engine_model

/* verif/tb_top.sv */
/* self-checking bench for the mailbox transmit request block.
 * assumes the engine model above on the far side and a 50 ns clock. */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, irq;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, send_en = 16'h0000, cancel_en = 16'h0000;
    logic [15:0] reg_rdata, tx_pending, cancel_pending, tx_complete, cancel_complete;
    int err_total = 0, cmp_count = 0;
    always #25 clk = ~clk;
    can_mailbox_tx_request_control uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .tx_pending(tx_pending), .cancel_pending(cancel_pending), .tx_complete(tx_complete),
        .cancel_complete(cancel_complete), .irq(irq));
    can_engine_model engine (.clk(clk), .resetn(resetn), .tx_pending(tx_pending),
        .cancel_pending(cancel_pending), .send_en(send_en), .cancel_en(cancel_en),
        .tx_complete(tx_complete), .cancel_complete(cancel_complete));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic [3:0] a, input logic [15:0] d, input logic w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= w;
        reg_read <= !w;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1;
    endtask : acc
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        acc(a, 16'h0000, 1'b0);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic knobs(input logic [15:0] s, input logic [15:0] c, input logic [15:0] m);
        int n;
        @(posedge clk);
        send_en <= s;
        cancel_en <= c;
        // bounded wait for the engine to finish the selected mailboxes
        for (n = 0; n < 20 && (tx_pending & m) !== 16'h0000; n++) @(posedge clk);
        send_en <= 16'h0000;
        cancel_en <= 16'h0000;
        if (n == 20) begin
            err_total++;
            stop_test();
        end
    endtask : knobs
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h0, 16'h0100);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        rd(4'h7, 16'h0000);
        $display("test reset done");
        acc(4'h0, 16'hffff, 1'b1);
        chk(tx_pending, 16'hfeff);
        acc(4'h0, 16'h0000, 1'b1);
        rd(4'h0, 16'hffff);
        knobs(16'h0008, 16'h0000, 16'h0008);
        rd(4'h0, 16'hfff7);
        rd(4'h2, 16'h0008);
        chk({15'h0000, irq}, 16'h0000);
        acc(4'h5, 16'h0001, 1'b1);
        @(posedge clk);
        #1;
        chk({15'h0000, irq}, 16'h0001);
        acc(4'h2, 16'h0000, 1'b1);
        rd(4'h2, 16'h0008);
        acc(4'h2, 16'h0008, 1'b1);
        acc(4'h4, 16'h0003, 1'b1);
        rd(4'h2, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        $display("test transmit done");
        // mailbox 3 is no longer waiting, so its cancel must be refused
        acc(4'h1, 16'h8108, 1'b1);
        chk(cancel_pending, 16'h8000);
        knobs(16'h0000, 16'hffff, 16'h8000);
        rd(4'h0, 16'h7ff7);
        rd(4'h1, 16'h0000);
        rd(4'h3, 16'h8000);
        acc(4'h1, 16'h0001, 1'b1);
        knobs(16'h0001, 16'h0001, 16'h0001);
        rd(4'h2, 16'h0001);
        rd(4'h3, 16'h8000);
        $display("test cancel done");
        stop_test();
    end
endmodule : tb_top
